// ==== logic/tsc_top.sv ====
// temperature sensor core: apb registers, conversion control and smbus slave
//
// Functional notes
// - registers keep reset values until changed
// - first conversion updates result and status
// - one-shot write in shutdown runs one conversion
// - one-shot pending: flag zero, result 8000h
// - other registers untouched by one-shot
// - one-shot end sets flag, loads result
// - two select bits choose 11..14 bits
// - default 11 bits, quarter degree lsb
// - result left-justified two's complement, sign bit15
// - bits below resolution read zero
// - fixed weights, one degree at bit7
// - slave only, clock line input only
// - address from pin level and variant
// - data line open-drain, pull low only
// - both lines glitch-filtered
// - bus-low timeout returns slave to idle
// - timeout lies within 15 to 45 ms
// - power-down bit7, current conversion finishes
// - power-up result reads 7FFCh
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
module tsc_top
   import tsc_pkg::*;
#(
   parameter logic [19:0] TMO_LIMIT = TMO_CYC,       // bus-low timeout in cycles
   parameter logic [23:0] CONV_CYC  = CONV_BASE_CYC, // 11-bit conversion cycles
   parameter logic        VARIANT   = 1'b0           // address variant bit
)(
   input  wire logic        pclk,     // system clock, 50 MHz
   input  wire logic        presetn,  // async reset, active low
   input  wire logic        psel,     // apb select
   input  wire logic        penable,  // apb enable
   input  wire logic        pwrite,   // apb direction
   input  wire logic [7:0]  paddr,    // apb byte address
   input  wire logic [31:0] pwdata,   // apb write data
   output logic      [31:0] prdata,   // apb read data
   output logic             pready,   // apb ready
   output logic             pslverr,  // apb error on unmapped address
   input  wire logic [13:0] adc_code, // converter code, lsb 1/32 degree
   input  wire logic [1:0]  addr_pin, // address pin: 0 float, 1 ground, 2 supply
   input  wire logic        scl_i,    // bus clock line, input only
   input  wire logic        sda_i,    // bus data line level
   output logic             sda_o,    // bus data drive value
   output logic             sda_oe_n  // bus data enable, low pulls line
);
   tsc_conv_if c ();

   ////////////////////////////////////////////////////////////////////////////
   // converter and line filters
   tsc_conv #(.CONV_CYC(CONV_CYC)) u_conv (
      .pclk    (pclk),
      .presetn (presetn),
      .c       (c)
   );

   logic scl_f, sda_f;
   tsc_filt u_scl (.pclk(pclk), .presetn(presetn), .line_i(scl_i), .line_q(scl_f));
   tsc_filt u_sda (.pclk(pclk), .presetn(presetn), .line_i(sda_i), .line_q(sda_f));

   ////////////////////////////////////////////////////////////////////////////
   // registers and conversion control
   logic        pdn_q, pdn_d;
   logic [1:0]  res_q, res_d;
   logic        dav_q, dav_d;
   logic        os_q, os_d;
   logic [15:0] temp_q, temp_d;
   logic [31:0] prdata_q, prdata_d;
   logic        wr_cfg, wr_cs, mapped;

   assign mapped  = paddr == OFS_TEMP || paddr == OFS_CONFIG || paddr == OFS_CTRL_STATUS;
   assign wr_cfg  = psel && penable && pwrite && paddr == OFS_CONFIG;
   assign wr_cs   = psel && penable && pwrite && paddr == OFS_CTRL_STATUS;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_q;
   assign c.res   = res_q;
   assign c.adc   = adc_code;

   // continuous runs start whenever the timer is free; in power-down only a
   // one-shot write starts one, and a run in flight always completes
   always_comb begin
      c.start  = 1'b0;
      pdn_d    = pdn_q;
      res_d    = res_q;
      dav_d    = dav_q;
      os_d     = os_q;
      temp_d   = temp_q;
      prdata_d = prdata_q;
      if (wr_cfg) begin
         pdn_d = pwdata[CFG_PWRDN_BIT];
      end
      if (wr_cs) begin
         res_d = {pwdata[CS_RES_HI_BIT], pwdata[CS_RES_LO_BIT]};
      end
      // completion goes first, so a one-shot started in the very cycle that an
      // earlier run ends still shows its pending marker and cleared flag
      if (c.done) begin
         temp_d = tsc_fmt(c.code, c.res_used);
         dav_d  = 1'b1;
         os_d   = 1'b0;
      end
      if (!pdn_q && c.ready) begin
         c.start = 1'b1;
      end else if (pdn_q && c.ready && !os_q && wr_cfg && pwdata[CFG_ONESHOT_BIT]) begin
         c.start = 1'b1;
         os_d    = 1'b1;
         dav_d   = 1'b0;
         temp_d  = TEMP_ONESHOT;
      end
      if (psel && !penable) begin
         unique case (paddr)
            OFS_TEMP:        prdata_d = {16'h0, temp_q};
            OFS_CONFIG:      prdata_d = 32'(pdn_q) << CFG_PWRDN_BIT;
            OFS_CTRL_STATUS: prdata_d = (32'(res_q) << CS_RES_LO_BIT) | 32'(dav_q);
            default:         prdata_d = 32'h0;
         endcase
      end
   end

   // reset values hold until a conversion or a write replaces them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pdn_q    <= 1'b0;
         res_q    <= RES_RST;
         dav_q    <= 1'b0;
         os_q     <= 1'b0;
         temp_q   <= TEMP_RST;
         prdata_q <= 32'h0;
      end else begin
         pdn_q    <= pdn_d;
         res_q    <= res_d;
         dav_q    <= dav_d;
         os_q     <= os_d;
         temp_q   <= temp_d;
         prdata_q <= prdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address pin strap, three stages, taken when the last two agree
   logic [1:0] ap1_q, ap2_q, ap3_q, asel_q, asel_d;
   logic [6:0] my_addr;

   assign my_addr = {SMB_ADDR_HI, VARIANT, asel_q};

   always_comb begin
      asel_d = (ap2_q == ap3_q) ? ap3_q : asel_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ap1_q  <= 2'h0;
         ap2_q  <= 2'h0;
         ap3_q  <= 2'h0;
         asel_q <= 2'h0;
      end else begin
         ap1_q  <= addr_pin;
         ap2_q  <= ap1_q;
         ap3_q  <= ap2_q;
         asel_q <= asel_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // smbus slave: samples on clock rise, changes data after clock fall
   tsc_smb_st_t st_q, st_d;
   logic        scl_p_q, sda_p_q;
   logic        drv_q, drv_d;
   logic [3:0]  bit_q, bit_d;
   logic [7:0]  sh_q, sh_d;
   logic        rw_q, rw_d;
   logic        nack_q, nack_d;
   logic        hi_q, hi_d;
   logic [15:0] word_q, word_d;
   logic [19:0] tmo_q, tmo_d;
   logic        scl_rise, scl_fall, start_c, stop_c, tmo_hit;

   assign scl_rise = scl_f && !scl_p_q;
   assign scl_fall = !scl_f && scl_p_q;
   assign start_c  = scl_f && scl_p_q && !sda_f && sda_p_q;
   assign stop_c   = scl_f && scl_p_q && sda_f && !sda_p_q;
   assign tmo_hit  = tmo_q >= TMO_LIMIT;
   // the clock line has no output at all; data is only ever pulled low
   assign sda_o    = 1'b0;
   assign sda_oe_n = !drv_q;

   // counts any stretch of low level on either filtered line
   always_comb begin
      tmo_d = (scl_f && sda_f) || tmo_hit ? 20'h0 : tmo_q + 20'h1;
   end

   always_comb begin
      st_d   = st_q;
      drv_d  = drv_q;
      bit_d  = bit_q;
      sh_d   = sh_q;
      rw_d   = rw_q;
      nack_d = nack_q;
      hi_d   = hi_q;
      word_d = word_q;
      unique case (st_q)
         TSC_IDLE: ;
         TSC_ADDR, TSC_RX: begin
            if (scl_rise) begin
               sh_d  = {sh_q[6:0], sda_f};
               bit_d = bit_q + 4'h1;
            end else if (scl_fall && bit_q == SMB_BITS) begin
               bit_d = 4'h0;
               if (st_q == TSC_RX) begin
                  st_d  = TSC_WACK;
                  drv_d = 1'b1;
               end else if (sh_q[7:1] == my_addr) begin
                  st_d   = TSC_AACK;
                  drv_d  = 1'b1;
                  rw_d   = sh_q[0];
                  word_d = temp_q;
               end else begin
                  st_d = TSC_IDLE;
               end
            end
         end
         TSC_AACK, TSC_WACK: begin
            if (scl_fall) begin
               if (st_q == TSC_AACK && rw_q) begin
                  st_d  = TSC_TX;
                  sh_d  = word_q[15:8];
                  drv_d = !word_q[15];
                  bit_d = 4'h1;
                  hi_d  = 1'b0;
               end else begin
                  st_d  = TSC_RX;
                  drv_d = 1'b0;
               end
            end
         end
         TSC_TX: begin
            if (scl_fall) begin
               if (bit_q == SMB_BITS) begin
                  st_d  = TSC_MACK;
                  drv_d = 1'b0;
               end else begin
                  sh_d  = {sh_q[6:0], 1'b0};
                  drv_d = !sh_q[6];
                  bit_d = bit_q + 4'h1;
               end
            end
         end
         TSC_MACK: begin
            if (scl_rise) begin
               nack_d = sda_f;
            end else if (scl_fall) begin
               if (nack_q) begin
                  st_d = TSC_IDLE;
               end else begin
                  st_d  = TSC_TX;
                  sh_d  = hi_q ? word_q[15:8] : word_q[7:0];
                  drv_d = hi_q ? !word_q[15] : !word_q[7];
                  hi_d  = !hi_q;
                  bit_d = 4'h1;
               end
            end
         end
      endcase
      if (start_c) begin
         st_d  = TSC_ADDR;
         bit_d = 4'h0;
         drv_d = 1'b0;
      end
      if (stop_c || tmo_hit) begin
         st_d  = TSC_IDLE;
         drv_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q    <= TSC_IDLE;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         drv_q   <= 1'b0;
         bit_q   <= 4'h0;
         sh_q    <= 8'h0;
         rw_q    <= 1'b0;
         nack_q  <= 1'b0;
         hi_q    <= 1'b0;
         word_q  <= 16'h0;
         tmo_q   <= 20'h0;
      end else begin
         st_q    <= st_d;
         scl_p_q <= scl_f;
         sda_p_q <= sda_f;
         drv_q   <= drv_d;
         bit_q   <= bit_d;
         sh_q    <= sh_d;
         rw_q    <= rw_d;
         nack_q  <= nack_d;
         hi_q    <= hi_d;
         word_q  <= word_d;
         tmo_q   <= tmo_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   power_up_temp_a: assert property (@(posedge pclk) disable iff (!presetn)
      !dav_q && !os_q |-> temp_q == TEMP_RST)
      else $error("result left its power-up value early");
   oneshot_state_a: assert property (@(posedge pclk) disable iff (!presetn)
      os_q |-> temp_q == TEMP_ONESHOT && !dav_q)
      else $error("one-shot state shows wrong result or flag");
   oneshot_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      pdn_q && c.ready && !os_q && wr_cfg && pwdata[CFG_ONESHOT_BIT] |=> os_q && !c.ready)
      else $error("one-shot write did not start a conversion");
   done_update_a: assert property (@(posedge pclk) disable iff (!presetn)
      c.done && !os_d |=> dav_q && !os_q && temp_q == tsc_fmt($past(c.code), $past(c.res_used)))
      else $error("completion did not load result and flag");
   low_bits_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      c.done |=> (temp_q & ~tsc_mask($past(c.res_used))) == 16'h0)
      else $error("bits below the resolution are set");
   oneshot_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      os_q && !wr_cfg && !wr_cs |=> $stable(pdn_q) && $stable(res_q))
      else $error("control changed during one-shot");
   pdn_no_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      pdn_q && !os_q && c.ready && !wr_cfg |=> c.ready)
      else $error("conversion started while powered down");
   timeout_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      tmo_hit |=> st_q == TSC_IDLE && sda_oe_n && tmo_q == 20'h0)
      else $error("timeout did not release the bus");
endmodule

// ==== pkg/tsc_pkg.sv ====
// shared constants, types and formatting helpers of the temperature sensor core
package tsc_pkg;
   // system clock and bus-low timeout
   localparam int          CLK_HZ          = 50_000_000;
   localparam int          TMO_MIN_MS      = 15;
   localparam int          TMO_MAX_MS      = 45;
   localparam logic [19:0] TMO_CYC         = 20'(TMO_MIN_MS * (CLK_HZ / 1000));
   // glitch filter stable time and base conversion time
   localparam logic [3:0]  FILT_CYC        = 4'h4;
   localparam logic [23:0] CONV_BASE_CYC   = 24'h000FA0;
   // apb register byte offsets
   localparam logic [7:0]  OFS_TEMP        = 8'h00;
   localparam logic [7:0]  OFS_CONFIG      = 8'h04;
   localparam logic [7:0]  OFS_CTRL_STATUS = 8'h08;
   // field positions
   localparam int          CFG_PWRDN_BIT   = 7;
   localparam int          CFG_ONESHOT_BIT = 2;
   localparam int          CS_RES_HI_BIT   = 6;
   localparam int          CS_RES_LO_BIT   = 5;
   localparam int          CS_DAV_BIT      = 0;
   // result values, reset resolution and smbus constants
   localparam logic [15:0] TEMP_RST        = 16'h7FFC;
   localparam logic [15:0] TEMP_ONESHOT    = 16'h8000;
   localparam logic [1:0]  RES_RST         = 2'h0;
   localparam logic [3:0]  SMB_ADDR_HI     = 4'h9;
   localparam logic [3:0]  SMB_BITS        = 4'h8;

   typedef enum {
      TSC_IDLE, TSC_ADDR, TSC_AACK, TSC_TX, TSC_MACK, TSC_RX, TSC_WACK
   } tsc_smb_st_t;

   // keeps only the bits that the selected word size carries
   function automatic logic [15:0] tsc_mask(input logic [1:0] res);
      tsc_mask = 16'(16'hFFFF << (3'h5 - {1'b0, res}));
   endfunction

   // left-justifies a 14-bit two's complement code, one degree at bit 7
   function automatic logic [15:0] tsc_fmt(input logic [13:0] code, input logic [1:0] res);
      tsc_fmt = {code, 2'h0} & tsc_mask(res);
   endfunction
endpackage

// ==== pkg/tsc_conv_if.sv ====
// bundle between the control logic and the conversion timer
`timescale 1ns/10ps
interface tsc_conv_if;
   logic        start;
   logic        ready;
   logic        done;
   logic [1:0]  res;
   logic [1:0]  res_used;
   logic [13:0] adc;
   logic [13:0] code;
   modport ctl  (output start, res, adc, input ready, done, code, res_used);
   modport conv (input start, res, adc, output ready, done, code, res_used);
endinterface

// ==== logic/tsc_filt.sv ====
// three-stage synchroniser with a stable-time glitch filter for one bus line
`timescale 1ns/10ps
module tsc_filt
   import tsc_pkg::*;
(
   input  wire logic pclk,    // system clock
   input  wire logic presetn, // async reset, active low
   input  wire logic line_i,  // raw bus line
   output logic      line_q   // filtered level
);
   logic [2:0] sync_q;
   logic [3:0] cnt_q, cnt_d;
   logic       line_d;

   // a change is believed only after it stays put for the filter time
   always_comb begin
      cnt_d  = 4'h0;
      line_d = line_q;
      if (sync_q[1] == sync_q[2] && sync_q[2] != line_q) begin
         cnt_d = cnt_q + 4'h1;
         if (cnt_q == FILT_CYC - 4'h1) begin
            line_d = sync_q[2];
            cnt_d  = 4'h0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_q <= 3'h7;
         cnt_q  <= 4'h0;
         line_q <= 1'b1;
      end else begin
         sync_q <= {sync_q[1:0], line_i};
         cnt_q  <= cnt_d;
         line_q <= line_d;
      end
   end

   filt_stable_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(line_q) |-> $past(sync_q[2], 2) == line_q && $past(sync_q[1]) == line_q)
      else $error("filtered line moved without a stable input");
endmodule

// ==== logic/tsc_conv.sv ====
// conversion timer whose length doubles with each added resolution bit
`timescale 1ns/10ps
module tsc_conv
   import tsc_pkg::*;
#(
   parameter logic [23:0] CONV_CYC = CONV_BASE_CYC // 11-bit conversion length
)(
   input  wire logic pclk,    // system clock
   input  wire logic presetn, // async reset, active low
   tsc_conv_if.conv  c        // control side
);
   logic        busy_q, busy_d;
   logic        done_q, done_d;
   logic [23:0] cnt_q, cnt_d;
   logic [1:0]  res_q, res_d;
   logic [13:0] code_q, code_d;

   assign c.ready    = !busy_q;
   assign c.done     = done_q;
   assign c.code     = code_q;
   assign c.res_used = res_q;

   // resolution is frozen at start so a mid-conversion change cannot skew it
   always_comb begin
      busy_d = busy_q;
      done_d = 1'b0;
      cnt_d  = cnt_q;
      res_d  = res_q;
      code_d = code_q;
      if (!busy_q && c.start) begin
         busy_d = 1'b1;
         res_d  = c.res;
         cnt_d  = 24'((CONV_CYC << c.res) - 24'h1);
      end else if (busy_q) begin
         cnt_d = cnt_q - 24'h1;
         if (cnt_q == 24'h0) begin
            busy_d = 1'b0;
            done_d = 1'b1;
            code_d = c.adc;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q  <= 24'h0;
         res_q  <= RES_RST;
         code_q <= 14'h0;
      end else begin
         busy_q <= busy_d;
         done_q <= done_d;
         cnt_q  <= cnt_d;
         res_q  <= res_d;
         code_q <= code_d;
      end
   end

   conv_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      !busy_q && c.start |=> busy_q && !done_q)
      else $error("conversion did not start");
   conv_done_a: assert property (@(posedge pclk) disable iff (!presetn)
      done_q |-> !busy_q && $past(busy_q) && $past(cnt_q) == 24'h0)
      else $error("done without an expired timer");
endmodule

// ==== bench/tsc_smb_master.sv ====
// smbus master model that drives the bus clock and data lines
`timescale 1ns/10ps
module tsc_smb_master (
   input  wire logic sda_line, // resolved data wire
   output logic      scl_pull, // high pulls clock low
   output logic      sda_pull  // high pulls data low
);
   logic lclk;

   // own link clock, phase unrelated to pclk, only paces this model
   initial begin
      lclk = 1'b0;
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      #7;
      forever #80 lclk = ~lclk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge lclk);
   endtask

   // a start only once the data line is back high, bounded wait
   task automatic start_c();
      int n;
      n = 0;
      while (sda_line !== 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      sda_pull <= 1'b1;
      tick(3);
      scl_pull <= 1'b1;
      tick(1);
   endtask

   // data moves while the clock is low; low phase 640 ns, high 480 ns
   task automatic clk_bit(input logic b, output logic s);
      sda_pull <= ~b;
      tick(3);
      scl_pull <= 1'b0;
      tick(2);
      s = sda_line;
      tick(1);
      scl_pull <= 1'b1;
      tick(1);
   endtask

   task automatic stop_c();
      sda_pull <= 1'b1;
      tick(2);
      scl_pull <= 1'b0;
      tick(2);
      sda_pull <= 1'b0;
      tick(8);
   endtask

   // start and read header, leaves the clock held low before the ack
   task automatic send_hdr(input logic [6:0] a);
      logic s;
      start_c();
      for (int i = 6; i >= 0; i--) clk_bit(a[i], s);
      clk_bit(1'b1, s);
   endtask

   task automatic read_word(input logic [6:0] a, output logic [15:0] d, output logic ack);
      logic s;
      d = 16'h0000;
      send_hdr(a);
      clk_bit(1'b1, s);
      ack = ~s;
      if (ack) begin
         for (int i = 15; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
            if (i == 8) clk_bit(1'b0, s); // ack between bytes
         end
         clk_bit(1'b1, s); // nack ends the read
      end
      stop_c();
   endtask

   task automatic free_bus();
      scl_pull <= 1'b0;
      sda_pull <= 1'b0;
      tick(8);
   endtask
endmodule

// ==== bench/temp_sensor_smbus_core_tb.sv ====
// self-checking bench of the temperature sensor core
`timescale 1ns/10ps
module temp_sensor_smbus_core_tb
   import tsc_pkg::*;
;
   localparam int CONV = 20;   // shortened 11-bit conversion
   localparam int TMO_N = 2000; // shortened, above any normal low phase
   localparam int SLOW = 2 * (CONV << 3) + 10;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r, lfsr;
   logic [13:0] adc_code, a;
   logic [1:0]  addr_pin;
   logic        sda_o, sda_oe_n, scl_w, sda_w, scl_pull, sda_pull, ack;
   logic [15:0] d, old;
   int          n_fail, samples_checked;

   // open-drain wires with pull-ups
   assign scl_w = ~scl_pull;
   assign sda_w = (sda_pull || sda_oe_n === 1'b0) ? 1'b0 : 1'b1;

   tsc_top #(.TMO_LIMIT(20'h007D0), .CONV_CYC(24'h000014), .VARIANT(1'b0)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .adc_code(adc_code), .addr_pin(addr_pin), .scl_i(scl_w),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
   tsc_smb_master m (.sda_line(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // one apb transfer; only the watchdog bounds the wait for pready
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return (x >> 1) ^ (x[0] ? 32'hA3000000 : 32'h00000000);
   endfunction

   // left-justified word, bits below the word size cleared
   function automatic logic [15:0] model_temp(input int v, input int res);
      int t;
      t = (v << 2) & 32'h0000FFFF;
      t = t & ~((1 << (5 - res)) - 1);
      return t[15:0];
   endfunction

   initial begin
      repeat (60000) @(posedge pclk);
      n_fail++;
      $display("watchdog expired");
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      adc_code = 14'h0320;
      addr_pin = 2'h0;
      lfsr = 32'hCF13CFE9;
      n_fail = 0;
      samples_checked = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_TEMP, 32'h0);
      chk(r, 32'h00007FFC);
      apb(1'b0, OFS_CTRL_STATUS, 32'h0);
      chk(r, 32'h00000000);
      apb(1'b0, OFS_CONFIG, 32'h0);
      chk(r, 32'h00000000);
      apb(1'b0, 8'h0C, 32'h0);
      chk({r[30:0], err_q}, 32'h00000001);
      repeat (CONV + 4) @(posedge pclk);
      apb(1'b0, OFS_TEMP, 32'h0);
      chk(r, 32'h00000C80);
      $display("test reset done");
      // every word size, fixed and random codes, read over both buses
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         a = (i == 0) ? 14'h0320 : (i == 1) ? 14'h3CE0 : lfsr[13:0];
         adc_code <= a;
         addr_pin <= 2'(i % 3);
         apb(1'b1, OFS_CTRL_STATUS, 32'(i << 5));
         repeat (SLOW) @(posedge pclk);
         apb(1'b0, OFS_TEMP, 32'h0);
         chk(r, {16'h0, model_temp(a, i)});
         apb(1'b0, OFS_CTRL_STATUS, 32'h0);
         chk(r, 32'((i << 5) | 1));
         m.read_word(7'(7'h48 + i % 3), d, ack);
         chk({31'h0, ack}, 32'h00000001);
         chk({16'h0, d}, {16'h0, model_temp(a, i)});
      end
      m.read_word(7'h4C, d, ack);
      chk({31'h0, ack}, 32'h00000000);
      $display("test resolution done");
      // shutdown: conversions stop, then a single one-shot
      apb(1'b1, OFS_CONFIG, 32'h00000080);
      repeat (SLOW) @(posedge pclk);
      old = model_temp(a, 3);
      lfsr = lfsr_next(lfsr);
      a = lfsr[13:0];
      adc_code <= a;
      repeat (SLOW) @(posedge pclk);
      apb(1'b0, OFS_TEMP, 32'h0);
      chk(r, {16'h0, old});
      apb(1'b1, OFS_CONFIG, 32'h00000084);
      apb(1'b0, OFS_TEMP, 32'h0);
      chk(r, 32'h00008000);
      apb(1'b0, OFS_CTRL_STATUS, 32'h0);
      chk(r, 32'h00000060);
      apb(1'b0, OFS_CONFIG, 32'h0);
      chk(r, 32'h00000080);
      repeat (SLOW) @(posedge pclk);
      apb(1'b0, OFS_TEMP, 32'h0);
      chk(r, {16'h0, model_temp(a, 3)});
      apb(1'b0, OFS_CTRL_STATUS, 32'h0);
      chk(r, 32'h00000061);
      adc_code <= ~a;
      repeat (SLOW) @(posedge pclk);
      apb(1'b0, OFS_TEMP, 32'h0);
      chk(r, {16'h0, model_temp(a, 3)});
      $display("test one-shot done");
      // clock held low in the ack slot until the slave gives up
      m.send_hdr(7'h48);
      repeat (20) @(posedge pclk);
      chk({31'h0, sda_oe_n}, 32'h00000000);
      chk({31'h0, sda_o}, 32'h00000000);
      repeat (TMO_N + 40) @(posedge pclk);
      chk({31'h0, sda_oe_n}, 32'h00000001);
      m.free_bus();
      m.read_word(7'h48, d, ack);
      chk({31'h0, ack}, 32'h00000001);
      chk({16'h0, d}, {16'h0, model_temp(a, 3)});
      $display("test timeout done");
      stop_test();
   end
endmodule
